// ### include/sas_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

`define SAS_ADDR_W        3
`define SAS_OFF_CTL_ZERO  3'h0
`define SAS_OFF_CTL_TWO   3'h1
`define SAS_OFF_RES_HIGH  3'h2
`define SAS_OFF_RES_LOW   3'h3
`define SAS_OFF_FLAG      3'h4
`define SAS_OFF_ENABLE    3'h5

`define SAS_BIT_ON        0
`define SAS_BIT_GO        1
`define SAS_BIT_JUSTIFY   7
`define SAS_ACQ_LSB       3
`define SAS_CLK_LSB       0
`define SAS_BIT_DONE      6
`define SAS_BIT_IRQ_EN    6

`define SAS_RST_ACQ       3'h0
`define SAS_RST_CLK       3'h0
`define SAS_RST_BYTE      8'h00

`define SAS_CONV_TADS     5'h0b
`define SAS_WAIT_TADS     5'h02
`define SAS_INSTR_CYCLES  4

`endif

// ### include/sas_pkg.sv
// Types shared by the converter sequencer
package sas_pkg;
  typedef enum logic [2:0] {
    SAS_IDLE,
    SAS_RC_DELAY,
    SAS_ACQUIRE,
    SAS_CONVERT,
    SAS_WAIT
  } sas_state_t;
endpackage

// ### hdl/sas_sequencer.sv
// Sequencer for a 10-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
`include "sas_map.svh"

module sas_sequencer
  import sas_pkg::*;
#(
  parameter int INSTR_CYCLES = `SAS_INSTR_CYCLES
) (
  // System
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // Register port
  input  wire logic [`SAS_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output var  logic [7:0]             regRdata,
  // Dedicated RC oscillator, synchronous level
  input  wire logic                   rcClock,
  // Power management
  input  wire logic                   sleepMode,
  output var  logic                   convIrq,
  output var  logic                   wakeRequest,
  // Compare unit
  input  wire logic                   compareTrigger,
  output var  logic                   timerClear,
  // Analog array
  input  wire logic                   cmpAbove,
  output var  logic                   sampleConnect,
  output var  logic                   analogPowered,
  output var  logic                   convActive,
  output var  logic [9:0]             sarTrial
);

  initial begin
    if (INSTR_CYCLES < 1 || INSTR_CYCLES > 255) begin
      $error("INSTR_CYCLES out of range");
    end
  end

  localparam logic [7:0] INSTR_LAST = 8'(INSTR_CYCLES - 1);

  // Acquisition periods per select code
  function automatic logic [4:0] acqPeriods(input logic [2:0] sel);
    logic [4:0] n;
    n = 5'h00;
    unique case (sel)
      3'h0: n = 5'h00;
      3'h1: n = 5'h02;
      3'h2: n = 5'h04;
      3'h3: n = 5'h06;
      3'h4: n = 5'h08;
      3'h5: n = 5'h0c;
      3'h6: n = 5'h10;
      3'h7: n = 5'h14;
    endcase
    return n;
  endfunction

  // Last divider count for each system clock division
  function automatic logic [5:0] divLast(input logic [2:0] sel);
    logic [5:0] n;
    n = 6'h01;
    unique case (sel)
      3'h0: n = 6'h01;
      3'h4: n = 6'h03;
      3'h1: n = 6'h07;
      3'h5: n = 6'h0f;
      3'h2: n = 6'h1f;
      3'h6: n = 6'h3f;
      default: n = 6'h01;
    endcase
    return n;
  endfunction

  // Trial bit for conversion period t (1 gives bit 9)
  function automatic logic [9:0] trialMask(input logic [4:0] t);
    logic [9:0] m;
    m = 10'h000;
    if (t >= 5'h01 && t <= 5'h0a) begin
      m = 10'h200 >> (t - 5'h01);
    end
    return m;
  endfunction

  // Undecided bits copy the last decided bit
  function automatic logic [9:0] fillPartial(input logic [9:0] r,
                                             input logic [4:0] t);
    logic [9:0] o;
    logic       last;
    o = r;
    last = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      if (5'(9 - i) < t - 5'h01) begin
        last = r[i];
      end else begin
        o[i] = last;
      end
    end
    if (t == 5'h00) begin
      o = 10'h000;
    end
    return o;
  endfunction

  // Result layout across the two bytes, high byte first
  function automatic logic [15:0] justify(input logic [9:0] r,
                                          input logic       right);
    return right ? {6'h00, r[9:8], r[7:0]}
                 : {r[9:2], r[1:0], 6'h00};
  endfunction

  sas_state_t state_q;
  sas_state_t state_d;
  logic       on_q;
  logic       go_q;
  logic       go_d;
  logic       justify_q;
  logic [2:0] acqSel_q;
  logic [2:0] clkSel_q;
  logic       done_q;
  logic       irqEn_q;
  logic       offSleep_q;
  logic       offSleep_d;
  logic [7:0] resHigh_q;
  logic [7:0] resLow_q;
  logic [9:0] sar_q;
  logic [9:0] sar_d;
  logic [5:0] divCnt_q;
  logic [4:0] tadCnt_q;
  logic [4:0] tadCnt_d;
  logic [7:0] dlyCnt_q;
  logic       rcPrev_q;

  // Decode
  wire        wrCtl0    = regWrite && regAddr == `SAS_OFF_CTL_ZERO;
  wire        wrCtl2    = regWrite && regAddr == `SAS_OFF_CTL_TWO;
  wire        wrHigh    = regWrite && regAddr == `SAS_OFF_RES_HIGH;
  wire        wrLow     = regWrite && regAddr == `SAS_OFF_RES_LOW;
  wire        wrFlag    = regWrite && regAddr == `SAS_OFF_FLAG;
  wire        wrEnable  = regWrite && regAddr == `SAS_OFF_ENABLE;
  wire        rcSel     = clkSel_q[1:0] == 2'b11;
  wire        busy      = state_q != SAS_IDLE;
  wire        running   = busy && state_q != SAS_WAIT;
  wire [4:0]  acqN      = acqPeriods(acqSel_q);
  wire        divHit    = divCnt_q == divLast(clkSel_q);
  wire        tadTick   = rcSel ? (rcClock && !rcPrev_q) : divHit;
  wire        powered   = on_q && !offSleep_q;
  // Requiring the on bit already set keeps a combined write inert
  wire        goRequest = (wrCtl0 && regWdata[`SAS_BIT_GO])
                          || compareTrigger;
  // A go that also clears the on bit, or lands as Sleep kills, stays inert
  wire        start     = goRequest && !busy && powered
                          && !offClear && !sleepKill;
  wire        swClear   = wrCtl0 && !regWdata[`SAS_BIT_GO];
  wire        offClear  = wrCtl0 && !regWdata[`SAS_BIT_ON];
  wire        sleepKill = sleepMode && !rcSel;
  wire        stop      = running && (swClear || offClear || sleepKill);
  wire        lastTad   = tadCnt_q == `SAS_CONV_TADS - 5'h01;
  wire        finish    = state_q == SAS_CONVERT && tadTick && lastTad
                          && !stop;
  wire [9:0]  finalRes  = cmpAbove ? (sar_q | 10'h001) : sar_q;
  wire [9:0]  abortRes  = fillPartial(sar_q, tadCnt_q);
  wire        storeRes  = finish || (stop && state_q == SAS_CONVERT);
  wire [15:0] resBytes  = justify(finish ? finalRes : abortRes,
                                  justify_q);
  wire        irqNext   = done_q && irqEn_q;

  // Sequence control
  always_comb begin
    state_d  = state_q;
    tadCnt_d = tadCnt_q;
    go_d     = go_q;
    if (stop) begin
      state_d  = SAS_WAIT;
      tadCnt_d = 5'h00;
      go_d     = 1'b0;
    end else begin
      unique case (state_q)
        SAS_IDLE: begin
          if (start) begin
            go_d     = 1'b1;
            tadCnt_d = 5'h00;
            if (rcSel) begin
              state_d = SAS_RC_DELAY;
            end else if (acqN == 5'h00) begin
              state_d = SAS_CONVERT;
            end else begin
              state_d = SAS_ACQUIRE;
            end
          end
        end
        SAS_RC_DELAY: begin
          if (dlyCnt_q == INSTR_LAST) begin
            state_d = acqN == 5'h00 ? SAS_CONVERT : SAS_ACQUIRE;
          end
        end
        SAS_ACQUIRE: begin
          if (tadTick) begin
            tadCnt_d = tadCnt_q + 5'h01;
            if (tadCnt_q == acqN - 5'h01) begin
              state_d  = SAS_CONVERT;
              tadCnt_d = 5'h00;
            end
          end
        end
        SAS_CONVERT: begin
          if (tadTick) begin
            tadCnt_d = tadCnt_q + 5'h01;
            if (lastTad) begin
              state_d  = SAS_WAIT;
              tadCnt_d = 5'h00;
              go_d     = 1'b0;
            end
          end
        end
        SAS_WAIT: begin
          if (tadTick) begin
            tadCnt_d = tadCnt_q + 5'h01;
            if (tadCnt_q == `SAS_WAIT_TADS - 5'h01) begin
              state_d  = SAS_IDLE;
              tadCnt_d = 5'h00;
            end
          end
        end
      endcase
    end
  end

  // Successive approximation register
  always_comb begin
    sar_d = sar_q;
    if (start) begin
      sar_d = 10'h000;
    end else if (state_q == SAS_CONVERT && tadTick
                 && tadCnt_q != 5'h00) begin
      if (cmpAbove) begin
        sar_d = sar_q | trialMask(tadCnt_q);
      end else begin
        sar_d = sar_q & ~trialMask(tadCnt_q);
      end
    end
  end

  // Power-down while the on bit stays set
  always_comb begin
    offSleep_d = offSleep_q;
    if (!sleepMode) begin
      offSleep_d = 1'b0;
    end else if (sleepKill) begin
      offSleep_d = 1'b1;
    end else if (finish && !irqEn_q) begin
      offSleep_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= SAS_IDLE;
      tadCnt_q   <= 5'h00;
      go_q       <= 1'b0;
      sar_q      <= 10'h000;
      offSleep_q <= 1'b0;
      rcPrev_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      tadCnt_q   <= tadCnt_d;
      go_q       <= go_d;
      sar_q      <= sar_d;
      offSleep_q <= offSleep_d;
      rcPrev_q   <= rcClock;
    end
  end

  // Divider restarts with each sequence and on abort, so periods are whole
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= 6'h00;
      dlyCnt_q <= 8'h00;
    end else begin
      divCnt_q <= (!busy || divHit || stop) ? 6'h00 : divCnt_q + 6'h01;
      dlyCnt_q <= state_q == SAS_RC_DELAY ? dlyCnt_q + 8'h01 : 8'h00;
    end
  end

  // Software registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      on_q      <= 1'b0;
      justify_q <= 1'b0;
      acqSel_q  <= `SAS_RST_ACQ;
      clkSel_q  <= `SAS_RST_CLK;
      irqEn_q   <= 1'b0;
    end else begin
      if (wrCtl0) begin
        on_q <= regWdata[`SAS_BIT_ON];
      end
      if (wrCtl2) begin
        justify_q <= regWdata[`SAS_BIT_JUSTIFY];
        acqSel_q  <= regWdata[`SAS_ACQ_LSB +: 3];
        clkSel_q  <= regWdata[`SAS_CLK_LSB +: 3];
      end
      if (wrEnable) begin
        irqEn_q <= regWdata[`SAS_BIT_IRQ_EN];
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (wrFlag) begin
      done_q <= regWdata[`SAS_BIT_DONE];
    end
  end

  // Hardware load beats a software write to the result bytes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resHigh_q <= `SAS_RST_BYTE;
      resLow_q  <= `SAS_RST_BYTE;
    end else if (storeRes) begin
      resHigh_q <= resBytes[15:8];
      resLow_q  <= resBytes[7:0];
    end else begin
      if (wrHigh) begin
        resHigh_q <= regWdata;
      end
      if (wrLow) begin
        resLow_q <= regWdata;
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  wire [7:0] readMux =
      regAddr == `SAS_OFF_CTL_ZERO ? {6'h00, go_q, on_q} :
      regAddr == `SAS_OFF_CTL_TWO  ? {justify_q, 1'b0, acqSel_q, clkSel_q} :
      regAddr == `SAS_OFF_RES_HIGH ? resHigh_q :
      regAddr == `SAS_OFF_RES_LOW  ? resLow_q :
      regAddr == `SAS_OFF_FLAG     ? {1'b0, done_q, 6'h00} :
      regAddr == `SAS_OFF_ENABLE   ? {1'b0, irqEn_q, 6'h00} : 8'h00;

  // Output flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdata      <= 8'h00;
      convIrq       <= 1'b0;
      wakeRequest   <= 1'b0;
      timerClear    <= 1'b0;
      sampleConnect <= 1'b0;
      analogPowered <= 1'b0;
      convActive    <= 1'b0;
      sarTrial      <= 10'h000;
    end else begin
      regRdata      <= regRead ? readMux : 8'h00;
      convIrq       <= irqNext;
      wakeRequest   <= irqNext && sleepMode;
      timerClear    <= compareTrigger;
      // Same power term as analogPowered, so sampling never outruns it
      sampleConnect <= on_q && !offSleep_d && (state_d == SAS_IDLE
                       || state_d == SAS_RC_DELAY
                       || state_d == SAS_ACQUIRE);
      analogPowered <= on_q && !offSleep_d;
      convActive    <= state_d == SAS_CONVERT;
      sarTrial      <= state_d == SAS_CONVERT
                       ? sar_d | trialMask(tadCnt_d) : 10'h000;
    end
  end

endmodule

`default_nettype wire

// ### tb/sas_sequencer_chk.sv
// Port-level assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none

module sas_sequencer_chk (
  // System
  input wire logic       clock,
  input wire logic       rst_n,
  // Register port
  input wire logic       regWrite,
  // Power and trigger
  input wire logic       sleepMode,
  input wire logic       convIrq,
  input wire logic       wakeRequest,
  input wire logic       compareTrigger,
  input wire logic       timerClear,
  // Analog side
  input wire logic       sampleConnect,
  input wire logic       analogPowered,
  input wire logic       convActive,
  input wire logic [9:0] sarTrial
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  trig_pulse_a: assert property (compareTrigger |=> timerClear)
    else $error("timer clear missing after trigger");
  trig_cause_a: assert property (timerClear |-> $past(compareTrigger))
    else $error("timer clear without trigger");
  wake_sleep_a: assert property (
    wakeRequest |-> convIrq && $past(sleepMode))
    else $error("wake request outside sleep or irq");
  flag_sticky_a: assert property ($fell(convIrq) |-> $past(regWrite, 2))
    else $error("irq dropped without software write");
  conv_power_a: assert property (convActive |-> analogPowered)
    else $error("conversion while unpowered");
  sample_power_a: assert property (sampleConnect |-> analogPowered)
    else $error("sampling while unpowered");
  hold_conv_a: assert property (convActive |-> !sampleConnect)
    else $error("channel connected during conversion");
  reconnect_wait_a: assert property (
    $fell(convActive) |-> !sampleConnect [*3])
    else $error("channel reconnected too early");
  trial_idle_a: assert property (!convActive |-> sarTrial == 10'h000)
    else $error("trial bits outside conversion");
endmodule

bind sas_sequencer sas_sequencer_chk i_chk (
  .clock(clock), .rst_n(rst_n), .regWrite(regWrite),
  .sleepMode(sleepMode), .convIrq(convIrq), .wakeRequest(wakeRequest),
  .compareTrigger(compareTrigger), .timerClear(timerClear),
  .sampleConnect(sampleConnect), .analogPowered(analogPowered),
  .convActive(convActive), .sarTrial(sarTrial)
);

`default_nettype wire

// ### tb/sas_analog_model.sv
// Behavioural analog array: comparator against a held input level
`timescale 1ns/1ps
`default_nettype none

module sas_analog_model (
  // System
  input  wire logic       clock,
  // Sequencer side
  input  wire logic [9:0] sarTrial,
  input  wire logic       convActive,
  output wire logic       cmpAbove,
  // Bench side
  input  wire logic [9:0] inLevel
);
  logic idleToggle_q;

  initial idleToggle_q = 1'b0;
  // Outside a conversion the comparator means nothing, so keep it moving
  always @(posedge clock) begin
    idleToggle_q <= ~idleToggle_q;
  end
  assign cmpAbove = convActive ? (inLevel >= sarTrial) : idleToggle_q;
endmodule

`default_nettype wire

// ### tb/sas_sequencer_tb_top.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sas_map.svh"

module sas_sequencer_tb_top;
  localparam logic [2:0] C0 = `SAS_OFF_CTL_ZERO, C2 = `SAS_OFF_CTL_TWO,
    RH = `SAS_OFF_RES_HIGH, RL = `SAS_OFF_RES_LOW, FL = `SAS_OFF_FLAG,
    EN = `SAS_OFF_ENABLE;
  logic       clock, rst_n, regWrite, regRead, rcClock, sleepMode;
  logic       compareTrigger, cmpAbove, convIrq, wakeRequest, timerClear;
  logic       sampleConnect, analogPowered, convActive;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic [9:0] sarTrial, inLevel;
  logic [1:0] rcDiv;
  int         error_cnt, num_checks, cycles, dly, len;

  sas_sequencer #(.INSTR_CYCLES(1)) i_dut (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .rcClock(rcClock), .sleepMode(sleepMode), .convIrq(convIrq),
    .wakeRequest(wakeRequest), .compareTrigger(compareTrigger),
    .timerClear(timerClear), .cmpAbove(cmpAbove),
    .sampleConnect(sampleConnect), .analogPowered(analogPowered),
    .convActive(convActive), .sarTrial(sarTrial));
  sas_analog_model i_ana (.clock(clock), .sarTrial(sarTrial),
    .convActive(convActive), .cmpAbove(cmpAbove), .inLevel(inLevel));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  assign rcClock = rcDiv[1];
  // Runaway guard; the whole sequence needs well under this
  always @(posedge clock) begin
    rcDiv <= rcDiv + 2'h1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic chkn(input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk8(exp, regRdata);
  endtask
  // Time the acquisition and conversion phases from here
  task automatic track(output int d, output int n);
    d = 0;
    n = 0;
    while (convActive !== 1'b1 && d < 3000) begin
      @(negedge clock);
      d++;
    end
    while (convActive === 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic settle;
    int k;
    k = 0;
    while (sampleConnect !== 1'b1 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    @(posedge clock);
  endtask
  task automatic run;
    wr(C0, 8'h03);
    track(dly, len);
  endtask

  task automatic t_clocks;
    logic [2:0] code [6];
    code = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    wr(C0, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(C2, {2'b10, 3'h0, code[i]});
      run();
      chkn(11 * (2 << i), len);
      settle();
      rd(C0, 8'h01);
      rd(RH, {6'h00, inLevel[9:8]});
      rd(RL, inLevel[7:0]);
    end
    rd(FL, 8'h40);
  endtask
  task automatic t_acq;
    int d0;
    logic [2:0] acqCode [5];
    int         acqExp [5];
    acqCode = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6};
    acqExp = '{2, 6, 8, 12, 16};
    wr(C2, 8'h00);
    run();
    d0 = dly;
    chkn(1, d0);
    settle();
    wr(C2, 8'h10);
    run();
    chkn(8, dly - d0);
    settle();
    rd(RH, inLevel[9:2]);
    rd(RL, {inLevel[1:0], 6'h00});
    wr(C2, 8'h78);
    rd(C2, 8'h38);
    run();
    chkn(40, dly - d0);
    settle();
    for (int i = 0; i < 5; i++) begin
      wr(C2, {2'b00, acqCode[i], 3'h0});
      run();
      chkn(2 * acqExp[i], dly - d0);
      settle();
    end
  endtask
  task automatic t_abort;
    inLevel <= 10'h3ff;
    wr(FL, 8'h00);
    wr(C2, 8'h81);
    wr(C0, 8'h03);
    repeat (40) @(posedge clock);
    wr(C0, 8'h01);
    settle();
    rd(RH, 8'h03);
    rd(RL, 8'hff);
    rd(FL, 8'h00);
  endtask
  task automatic t_sleep;
    wr(C0, 8'h03);
    repeat (20) @(posedge clock);
    sleepMode <= 1'b1;
    repeat (3) @(negedge clock);
    chk8(8'h00, {6'h00, convActive, analogPowered});
    rd(C0, 8'h01);
    sleepMode <= 1'b0;
    settle();
  endtask
  task automatic t_rc(input logic en);
    wr(EN, {1'b0, en, 6'h00});
    wr(C2, 8'h03);
    sleepMode <= 1'b1;
    run();
    chkn(2, dly);
    repeat (2) @(negedge clock);
    chk8({5'h0, {3{en}}},
         {5'h0, convIrq, wakeRequest, analogPowered});
    rd(C0, 8'h01);
    sleepMode <= 1'b0;
    wr(FL, 8'h00);
    repeat (3) @(negedge clock);
    chk8(8'h00, {7'h00, convIrq});
    settle();
  endtask
  task automatic t_trig;
    wr(C2, 8'h80);
    // Second go lands two cycles into the run; a restart would stretch it
    wr(C0, 8'h03);
    wr(C0, 8'h03);
    track(dly, len);
    chkn(11 * 2 - 1, len);
    settle();
    @(posedge clock);
    compareTrigger <= 1'b1;
    @(posedge clock);
    compareTrigger <= 1'b0;
    #1 chk8(8'h01, {7'h00, timerClear});
    rd(C0, 8'h03);
    settle();
  endtask
  task automatic t_rst;
    wr(C2, 8'h81);
    wr(C0, 8'h03);
    repeat (30) @(posedge clock);
    rst_n <= 1'b0;
    @(negedge clock);
    chk8(8'h00, {7'h00, convActive});
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rd(C0, 8'h00);
    rd(C2, 8'h00);
    wr(C0, 8'h02);
    rd(C0, 8'h00);
    wr(C0, 8'h03);
    rd(C0, 8'h01);
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    {rst_n, regWrite, regRead, sleepMode, compareTrigger} = 5'h00;
    {regAddr, regWdata, rcDiv} = 13'h0000;
    inLevel = 10'h2b5;
    {cycles, error_cnt, num_checks} = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rd(C2, 8'h00);
    rd(C0, 8'h00);
    rd(3'h7, 8'h00);
    t_clocks();
    t_acq();
    t_abort();
    t_sleep();
    t_rc(1'b1);
    t_rc(1'b0);
    t_trig();
    t_rst();
    end_of_test();
  end
endmodule

`default_nettype wire
